/* File: hw/ddrs_map.vh */
`ifndef DDRS_MAP_VH
`define DDRS_MAP_VH

// data path widths (x18 organisation, x8 uses the low byte)
`define DDRS_DATA_W       18
`define DDRS_ADDR_W       4
`define DDRS_WORD_AW      5
`define DDRS_DEPTH        32
`define DDRS_BYTE_LANES   2
`define DDRS_BYTE_W       9
`define DDRS_NIB_LANES    2
`define DDRS_NIB_W        4
`define DDRS_X8_W         8

// burst address bit values
`define DDRS_BEAT_FIRST   1'h0
`define DDRS_BEAT_SECOND  1'h1

// beat phase of the internal clock
`define DDRS_PH_PRIMARY   1'h0
`define DDRS_PH_COMPL     1'h1

// impedance calibration
`define DDRS_CODE_W       4
`define DDRS_CODE_RESET   4'h8
`define DDRS_CODE_MAX     4'hF
`define DDRS_CODE_MIN     4'h0
`define DDRS_CODE_STEP    4'h1
`define DDRS_CAL_CNT_W    10
`define DDRS_CAL_PERIOD   10'h3FF
`define DDRS_CAL_CNT_ONE  10'h001
`define DDRS_CAL_CNT_ZERO 10'h000

// termination strength select levels
`define DDRS_TERM_STRONG  1'h0
`define DDRS_TERM_WEAK    1'h1

// reset values
`define DDRS_DQ_RESET     18'h00000
`define DDRS_ADDR_RESET   4'h0
`define DDRS_MASK_RESET   2'h3

`endif

/* File: hw/ddrs_lane_merge.v */
`include "ddrs_map.vh"

// merges one write beat into the stored word, lane by lane
module ddrs_lane_merge
(
  input  wire [`DDRS_DATA_W-1:0]     old_word,
  input  wire [`DDRS_DATA_W-1:0]     new_word,
  input  wire [`DDRS_BYTE_LANES-1:0] byte_mask_n,
  input  wire [`DDRS_NIB_LANES-1:0]  nibble_mask_n,
  input  wire                        x8_mode,
  output wire [`DDRS_DATA_W-1:0]     merged_word,
  output wire                        any_lane
);

  genvar b;
  generate
    for (b = 0; b < `DDRS_DATA_W; b = b + 1)
    begin : g_bit
      wire take_bit;
      // a high mask keeps the stored bit; x8 bits above the byte never change
      if (b < `DDRS_X8_W)
      begin : g_low
        assign take_bit = x8_mode ? ~nibble_mask_n[b / `DDRS_NIB_W]
                                  : ~byte_mask_n[b / `DDRS_BYTE_W];
      end
      else
      begin : g_high
        assign take_bit = ~x8_mode & ~byte_mask_n[b / `DDRS_BYTE_W];
      end
      assign merged_word[b] = take_bit ? new_word[b] : old_word[b];
    end
  endgenerate

  assign any_lane = x8_mode ? ~(&nibble_mask_n) : ~(&byte_mask_n);

endmodule

/* File: hw/ddrs_sram_core.v */
// Overview of operation
// [R1] every accepted read or write moves exactly two beats, never cut short
// [R2] controller may load a command every cycle or insert deselects
// [R3] deselect pipelined like a read; read finishes, then outputs float
// [R4] load strobe high ignores command inputs and deselects after bursts
// [R5] address, load strobe and read select sampled on primary rise only
// [R6] load low: read select high reads, low writes
// [R7] first read beat at primary edge n+2, second on next complementary
// [R8] controller gives first write beat at primary edge n+1
// [R9] second write beat captured at the complementary rise after the first
// [R10] masks sampled with each write beat, one mask per beat
// [R11] high byte mask keeps that 9-bit lane unchanged for that beat
// [R12] 8-bit variant masks 4-bit nibbles with nibble masks instead
// [R13] all masks high on both beats stores nothing: write abort
// [R14] one-bit burst counter: low address bit 0 then 1
// [R15] nop or write disables data drivers one cycle, 2.0 cycles later
// [R16] termination always on; select low strong, high weak
// [R17] cycle counter periodically triggers impedance evaluation and restarts
// [R18] each evaluation moves drive code at most one step
// [R19] termination code recalibrated by the same counter and step
// [R20] controller always drives data, masks and clocks to defined levels
// [R21] controller avoids bus contention and leaves turnaround after reads
`include "ddrs_map.vh"

// one clk period is half a memory clock: phase 0 is the primary rise,
// phase 1 the complementary rise.  both beats therefore land on clk edges.
module ddrs_sram_core
(
  input  wire                        clk,
  input  wire                        rst_n,
  input  wire                        clk_en,
  input  wire                        x8_mode,
  input  wire                        cmd_load_n,
  input  wire                        cmd_read,
  input  wire [`DDRS_ADDR_W-1:0]     sync_address,
  input  wire [`DDRS_DATA_W-1:0]     dq_in,
  input  wire [`DDRS_BYTE_LANES-1:0] byte_mask_n,
  input  wire [`DDRS_NIB_LANES-1:0]  nibble_mask_n,
  input  wire                        term_strength_sel,
  input  wire                        impedance_too_high,
  output reg  [`DDRS_DATA_W-1:0]     dq_out_reg,
  output reg                         dq_oe_n_reg,
  output reg                         k_phase_reg,
  output reg  [`DDRS_CODE_W-1:0]     drive_code_reg,
  output reg  [`DDRS_CODE_W-1:0]     term_code_reg,
  output reg                         term_weak_reg
);

  localparam ST_IDLE  = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_READ  = 3'h4;

  reg  [`DDRS_DATA_W-1:0]    mem_reg [0:`DDRS_DEPTH-1];

  // stage 1: command taken at primary edge n
  reg  [2:0]                 s1_state_reg;
  reg  [`DDRS_ADDR_W-1:0]    s1_addr_reg;
  // stage 2: same command one memory cycle later (edge n+1)
  reg  [2:0]                 s2_state_reg;
  reg  [`DDRS_ADDR_W-1:0]    s2_addr_reg;
  // stage 3: the second read beat follows one clk after the first, but the
  // pipeline has already moved on, so its base address is kept here
  reg                        beat2_due_reg;
  reg  [`DDRS_ADDR_W-1:0]    rd_hold_reg;

  reg  [`DDRS_CAL_CNT_W-1:0] cal_cnt_reg;
  reg  [`DDRS_CAL_CNT_W-1:0] cal_cnt_next;
  reg  [`DDRS_CODE_W-1:0]    drive_code_next;
  reg  [`DDRS_CODE_W-1:0]    term_code_next;
  reg                        cal_fire;

  wire                       ph_primary;
  wire                       ph_compl;
  reg  [2:0]                 cmd_state;
  reg  [`DDRS_WORD_AW-1:0]   wr_index;
  reg  [`DDRS_WORD_AW-1:0]   rd_index;
  reg                        wr_active;
  wire [`DDRS_DATA_W-1:0]    merged_word;
  wire                       any_lane;

  assign ph_primary = (k_phase_reg == `DDRS_PH_PRIMARY);
  assign ph_compl   = (k_phase_reg == `DDRS_PH_COMPL);

  // command decode, only meaningful on a primary rise
  always @*
  begin
    if (cmd_load_n)
      cmd_state = ST_IDLE;             // see [R4]
    else if (cmd_read)
      cmd_state = ST_READ;             // see [R6]
    else
      cmd_state = ST_WRITE;            // see [R6]
  end

  // burst beat selects the low word address bit
  always @*
  begin
    wr_active = 1'b0;
    wr_index  = {s1_addr_reg, `DDRS_BEAT_FIRST};
    rd_index  = {s2_addr_reg, `DDRS_BEAT_FIRST};
    case (s1_state_reg)
      ST_WRITE:
        wr_active = ph_primary;        // see [R8]
      default:
        wr_active = 1'b0;
    endcase
    if (ph_compl)
    begin
      case (s2_state_reg)
        ST_WRITE:
          wr_active = 1'b1;            // see [R9]
        default:
          wr_active = 1'b0;
      endcase
      wr_index = {s2_addr_reg, `DDRS_BEAT_SECOND}; // see [R14]
      rd_index = {rd_hold_reg, `DDRS_BEAT_SECOND}; // see [R14]
    end
  end

  // masks are sampled with the beat they belong to
  ddrs_lane_merge u_merge
  (
    .old_word      (mem_reg[wr_index]),
    .new_word      (dq_in),
    .byte_mask_n   (byte_mask_n),      // see [R10]
    .nibble_mask_n (nibble_mask_n),    // see [R12]
    .x8_mode       (x8_mode),
    .merged_word   (merged_word),      // see [R11]
    .any_lane      (any_lane)
  );

  // storage; a beat with every lane masked writes nothing, so a write with
  // both beats fully masked leaves memory untouched
  always @(posedge clk)
  begin
    if (clk_en && wr_active && any_lane)  // see [R13]
      mem_reg[wr_index] <= merged_word;   // see [R11]
  end

  // beat phase and command pipeline
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      k_phase_reg  <= `DDRS_PH_PRIMARY;
      s1_state_reg <= ST_IDLE;
      s1_addr_reg  <= `DDRS_ADDR_RESET;
      s2_state_reg <= ST_IDLE;
      s2_addr_reg  <= `DDRS_ADDR_RESET;
    end
    else if (clk_en)
    begin
      k_phase_reg <= ~k_phase_reg;
      if (ph_primary)
      begin
        // command and address inputs are looked at only here, never on the complementary rise
        s1_state_reg <= cmd_state;     // see [R5]
        s1_addr_reg  <= sync_address;  // see [R5]
        // a command once taken always runs through both beats
        s2_state_reg <= s1_state_reg;  // see [R1]
        s2_addr_reg  <= s1_addr_reg;
      end
    end
  end

  // read data and driver enable; deselect and write walk the same two
  // stages as a read, so a deselect right after a read lets both read
  // beats out before the drivers float
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out_reg    <= `DDRS_DQ_RESET;
      dq_oe_n_reg   <= 1'b1;
      beat2_due_reg <= 1'b0;
      rd_hold_reg   <= `DDRS_ADDR_RESET;
    end
    else if (clk_en)
    begin
      if (ph_primary)
      begin
        if (s2_state_reg == ST_READ)
        begin
          dq_out_reg    <= mem_reg[rd_index];  // see [R7]
          dq_oe_n_reg   <= 1'b0;
          beat2_due_reg <= 1'b1;               // see [R1]
          rd_hold_reg   <= s2_addr_reg;
        end
        else
        begin
          dq_oe_n_reg   <= 1'b1;               // see [R15] see [R3]
          beat2_due_reg <= 1'b0;
        end
      end
      else if (beat2_due_reg)
        dq_out_reg <= mem_reg[rd_index];       // see [R14]
    end
  end

  // calibration timer: fires once per period then restarts
  always @*
  begin
    cal_fire     = (cal_cnt_reg == `DDRS_CAL_PERIOD);  // see [R17]
    cal_cnt_next = cal_cnt_reg + `DDRS_CAL_CNT_ONE;
    if (cal_fire)
      cal_cnt_next = `DDRS_CAL_CNT_ZERO;               // see [R17]
  end

  // single-step move toward the reference; saturation avoids wrapping a
  // strong driver into its weakest code
  always @*
  begin
    drive_code_next = drive_code_reg;
    term_code_next  = term_code_reg;
    if (cal_fire)
    begin
      if (impedance_too_high)
      begin
        if (drive_code_reg != `DDRS_CODE_MAX)
          drive_code_next = drive_code_reg + `DDRS_CODE_STEP; // see [R18]
        if (term_code_reg != `DDRS_CODE_MAX)
          term_code_next = term_code_reg + `DDRS_CODE_STEP;   // see [R19]
      end
      else
      begin
        if (drive_code_reg != `DDRS_CODE_MIN)
          drive_code_next = drive_code_reg - `DDRS_CODE_STEP; // see [R18]
        if (term_code_reg != `DDRS_CODE_MIN)
          term_code_next = term_code_reg - `DDRS_CODE_STEP;   // see [R19]
      end
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_cnt_reg    <= `DDRS_CAL_CNT_ZERO;
      drive_code_reg <= `DDRS_CODE_RESET;
      term_code_reg  <= `DDRS_CODE_RESET;
      term_weak_reg  <= `DDRS_TERM_WEAK;
    end
    else if (clk_en)
    begin
      cal_cnt_reg    <= cal_cnt_next;
      drive_code_reg <= drive_code_next;
      term_code_reg  <= term_code_next;
      // termination never switches off, only its strength follows the pin
      term_weak_reg  <= (term_strength_sel == `DDRS_TERM_WEAK); // see [R16]
    end
  end

endmodule

/* File: verification/ddrs_sram_monitor.sv */
`include "ddrs_map.vh"
module ddrs_sram_monitor
(
  input wire       clk,
  input wire       rst_n,
  input wire       clk_en,
  input wire       cmd_load_n,
  input wire       cmd_read,
  input wire       term_strength_sel,
  input wire       impedance_too_high,
  input wire       dq_oe_n_reg,
  input wire       k_phase_reg,
  input wire [3:0] drive_code_reg,
  input wire [3:0] term_code_reg,
  input wire       term_weak_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg  [9:0] cnt_reg;
  wire       p0;
  assign p0 = clk_en && !k_phase_reg;
  // mirrors the calibration period so code moves can be placed in time
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt_reg <= 10'h000;
    else if (clk_en)
      cnt_reg <= cnt_reg + 10'h001;
  phase_flip_a: assert property
    (clk_en |=> k_phase_reg != $past(k_phase_reg))
    else $error("phase did not alternate");
  read_beats_a: assert property
    (p0 && !cmd_load_n && cmd_read |-> ##5 !dq_oe_n_reg [*2])
    else $error("read beats not driven");
  idle_float_a: assert property
    (p0 && (cmd_load_n || !cmd_read) |-> ##5 dq_oe_n_reg)
    else $error("drivers not released");
  term_follow_a: assert property
    (1'b1 |=> term_weak_reg == $past(term_strength_sel))
    else $error("termination strength wrong");
  drive_step_a: assert property
    ($changed(drive_code_reg) |->
     drive_code_reg - $past(drive_code_reg) inside {4'h1, 4'hF})
    else $error("drive code jumped");
  term_step_a: assert property
    ($changed(term_code_reg) |->
     term_code_reg - $past(term_code_reg) inside {4'h1, 4'hF})
    else $error("termination code jumped");
  cal_period_a: assert property
    ($changed(drive_code_reg) || $changed(term_code_reg) |-> cnt_reg == 0)
    else $error("code moved off period");
  cal_up_a: assert property
    (cnt_reg == 10'h000 && $past(cnt_reg) == 10'h3FF &&
     $past(impedance_too_high) && $past(drive_code_reg) != 4'hF
     |-> drive_code_reg == $past(drive_code_reg) + 4'h1)
    else $error("drive code did not step up");
  cover property (p0 && !cmd_load_n && cmd_read);
  cover property (p0 && !cmd_load_n && !cmd_read);
  cover property ($changed(drive_code_reg));
endmodule
bind ddrs_sram_core ddrs_sram_monitor u_mon
(
  .clk, .rst_n, .clk_en, .cmd_load_n, .cmd_read, .term_strength_sel,
  .impedance_too_high, .dq_oe_n_reg, .k_phase_reg, .drive_code_reg,
  .term_code_reg, .term_weak_reg
);

/* File: verification/ddrs_ctrl_model.sv */
module ddrs_ctrl_model
(
  input  wire        clk,
  input  wire        drive,
  input  wire [17:0] data,
  output wire [17:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // undriven bus toggles each cycle so stale data can never match
  reg [17:0] idle_reg = 18'h15555;
  always @(posedge clk)
    idle_reg <= ~idle_reg;
  assign dq_in = drive ? data : idle_reg;
endmodule

/* File: verification/tb_ddr_burst2_sram_interface.sv */
`include "ddrs_map.vh"
`define CHK(nm, e, g) \
  begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_ddr_burst2_sram_interface;
  timeunit 1ns;
  timeprecision 100ps;
  reg         clk = 0, rst_n = 0, x8 = 0, ld_n = 1, rd = 0;
  reg         drv = 0, tsel = 1, hi = 1, tx, en = 1;
  reg  [3:0]  addr = 0, ta;
  reg  [1:0]  msk = 2'h0, tm1, tm2;
  reg  [17:0] wd = 0, r1, r2, e1, e2, mk;
  wire [17:0] dq_in, q;
  wire [3:0]  dc, tc;
  wire        oe_n, ph, tw;
  integer     n_fail = 0, cmp_count = 0, cyc = 0, i;
  // fields: address, x8, beat1 mask, beat2 mask, expected beat1 read data, expected beat2 read data
  localparam [44:0] TBL [0:5] = '{
    {4'h1, 1'h0, 2'h0, 2'h3, 18'h3FFFF, 18'h00000},
    {4'h2, 1'h0, 2'h1, 2'h2, 18'h3FE00, 18'h000AA},
    {4'h3, 1'h0, 2'h3, 2'h3, 18'h00000, 18'h00000},
    {4'hF, 1'h0, 2'h0, 2'h0, 18'h3FFFF, 18'h2AAAA},
    {4'h5, 1'h1, 2'h2, 2'h1, 18'h0000F, 18'h000A0},
    {4'h6, 1'h1, 2'h1, 2'h2, 18'h000F0, 18'h0000A}};
  ddrs_ctrl_model u_ctrl (.clk(clk), .drive(drv), .data(wd), .dq_in(dq_in));
  // the unused mask set gets the inverse, so the wrong one is caught
  ddrs_sram_core dut (.clk(clk), .rst_n(rst_n), .clk_en(en),
    .x8_mode(x8), .cmd_load_n(ld_n), .cmd_read(rd), .sync_address(addr),
    .dq_in(dq_in), .byte_mask_n(x8 ? ~msk : msk),
    .nibble_mask_n(x8 ? msk : ~msk), .term_strength_sel(tsel),
    .impedance_too_high(hi), .dq_out_reg(q), .dq_oe_n_reg(oe_n),
    .k_phase_reg(ph), .drive_code_reg(dc), .term_code_reg(tc),
    .term_weak_reg(tw));
  initial
    forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task step;
    @(posedge clk);
    #1;
  endtask
  task do_reset;
    rst_n = 0;
    repeat (2) step();
    rst_n = 1;
  endtask
  task op(input reg r, input reg [3:0] a, input reg [17:0] d1, d2,
          input reg [1:0] m1, m2);
    while (ph !== 1'b0)
      step();
    ld_n = 0;
    rd = r;
    addr = a;
    step();
    ld_n = 1;
    addr = ~a;
    step();
    drv = !r;
    wd = d1;
    msk = m1;
    step();
    wd = d2;
    msk = m2;
    step();
    drv = 0;
    msk = 2'h3;
    step();
    r1 = q;
    step();
    r2 = q;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    do_reset();
    `CHK("oe_reset", 1'b1, oe_n)
    `CHK("code_reset", 4'h8, dc)
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      {ta, tx, tm1, tm2, e1, e2} = TBL[i];
      x8 = 0;
      op(0, ta, 18'h00000, 18'h00000, 2'h0, 2'h0);
      x8 = tx;
      mk = tx ? 18'h000FF : 18'h3FFFF;
      op(0, ta, 18'h3FFFF, 18'h2AAAA, tm1, tm2);
      op(1, ta, 18'h00000, 18'h00000, 2'h3, 2'h3);
      `CHK("beat1", e1, r1 & mk)
      `CHK("beat2", e2, r2 & mk)
      `CHK("oe_read", 1'b0, oe_n)
      step();
      `CHK("oe_desel", 1'b1, oe_n)
    end
    $display("test burst table done");
    tsel = 0;
    step();
    `CHK("term_strong", 1'b0, tw)
    tsel = 1;
    step();
    `CHK("term_weak", 1'b1, tw)
    $display("test termination done");
    tx = ph;
    en = 0;
    repeat (3) step();
    `CHK("freeze_phase", tx, ph)
    en = 1;
    step();
    `CHK("thaw_phase", ~tx, ph)
    $display("test clock enable done");
    do_reset();
    repeat (1023) step();
    `CHK("code_early", 4'h8, dc)
    step();
    `CHK("drive_up", 4'h9, dc)
    `CHK("term_up", 4'h9, tc)
    hi = 0;
    repeat (1024) step();
    `CHK("drive_down", 4'h8, dc)
    $display("test calibration done");
    complete_run();
  end
endmodule
